// >>> core/ptp_cfg.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Ten-meg enable bit emits chosen test pattern.
// [R2] Extended enable bit starts hundred-meg test mode.
// [R3] Four-bit field picks the ten-meg pattern.
// [R4] Five-bit value gives zeros after each one.
// [R5] All-zero hundred selection clears shift register.
// [R6] Software toggles enable off/on to change pattern.
// [R7] Software forces link speed before any test.
// [R8] Bit 14 picks preamble mode, resets short.
// [R9] Preamble mode touches only ten-meg reception.
// [R10] Long mode needs seven preamble bytes.
// [R11] Short mode accepts preambles above three bytes.
// [R12] MAC may see fewer preamble bytes.
// [R13] Software picks short mode for short-preamble partners.
module ptp_cfg (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ptp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ptp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ptp_pkg::DATA_W-1:0] reg_rdata_ff,
  input wire logic speed_100,
  input wire logic rx_crs,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  output logic test_active_ff,
  output logic test_hundred_ff,
  output logic test_bit_ff,
  output logic test_idle_ff,
  output logic [1:0] test_idle_code_ff,
  output logic mac_valid_ff,
  output logic [7:0] mac_byte_ff,
  output logic frame_ok_ff,
  output logic frame_drop_ff
);
  import ptp_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] compliance_test_select_ff;
  logic [DATA_W-1:0] ten_meg_preamble_config_ff;
  logic ext_enable_ff;
  logic ext_sel_hi_ff;
  logic [DATA_W-1:0] nxt_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
    return a == off[ADDR_W-1:0];
  endfunction

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      compliance_test_select_ff <= RST_COMPLIANCE_TEST_SELECT;
    end else if (reg_wr && hit(reg_addr, OFF_COMPLIANCE_TEST_SELECT)) begin
      compliance_test_select_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ten_meg_preamble_config_ff <= RST_TEN_MEG_PREAMBLE_CONFIG; // [R8]
    end else if (reg_wr && hit(reg_addr, OFF_TEN_MEG_PREAMBLE_CONFIG)) begin
      ten_meg_preamble_config_ff <= reg_wdata;
      ten_meg_preamble_config_ff[BIT_PREAMBLE_RSVD_RO] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_enable_ff <= RST_HUNDRED_TEST_EXT[BIT_TEST_ENABLE];
      ext_sel_hi_ff <= RST_HUNDRED_TEST_EXT[BIT_HUNDRED_SEL_HI];
    end else if (reg_wr && hit(reg_addr, OFF_HUNDRED_TEST_EXT)) begin
      ext_enable_ff <= reg_wdata[BIT_TEST_ENABLE];
      ext_sel_hi_ff <= reg_wdata[BIT_HUNDRED_SEL_HI];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    if (hit(reg_addr, OFF_COMPLIANCE_TEST_SELECT)) begin
      nxt_rdata = compliance_test_select_ff;
    end else if (hit(reg_addr, OFF_TEN_MEG_PREAMBLE_CONFIG)) begin
      nxt_rdata = ten_meg_preamble_config_ff;
    end else if (hit(reg_addr, OFF_HUNDRED_TEST_EXT)) begin
      nxt_rdata[BIT_TEST_ENABLE] = ext_enable_ff;
      nxt_rdata[BIT_HUNDRED_SEL_HI] = ext_sel_hi_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Pattern selection capture
  // ----------------------------------------------------------------
  // A selection is taken only on the rising edge of an enable, so a new
  // value written while the mode runs waits for the next off/on toggle.
  logic ten_en;
  logic ten_en_d_ff;
  logic ext_en_d_ff;
  logic [SEL_W-1:0] ten_sel_ff;
  logic [SEL_W:0] zeros_ff;
  ptp_gen_t gen_ff;
  ptp_gen_t nxt_gen;

  assign ten_en = compliance_test_select_ff[BIT_TEST_ENABLE];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ten_en_d_ff <= 1'b0;
      ext_en_d_ff <= 1'b0;
    end else begin
      ten_en_d_ff <= ten_en;
      ext_en_d_ff <= ext_enable_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ten_sel_ff <= '0;
    end else if (ten_en && !ten_en_d_ff) begin
      ten_sel_ff <= compliance_test_select_ff[SEL_LSB +: SEL_W]; // [R3]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      zeros_ff <= '0;
    end else if (ext_enable_ff && !ext_en_d_ff) begin
      zeros_ff <= {ext_sel_hi_ff, compliance_test_select_ff[SEL_LSB +: SEL_W]}; // [R4] [R6]
    end
  end

  // Hundred-meg mode takes precedence; the forced speed is kept elsewhere.
  always_comb begin
    if (ext_enable_ff && ext_en_d_ff) begin
      nxt_gen = PTP_GEN_HUNDRED; // [R2] [R7]
    end else if (ten_en && ten_en_d_ff) begin
      nxt_gen = PTP_GEN_TEN; // [R1] [R7]
    end else begin
      nxt_gen = PTP_GEN_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gen_ff <= PTP_GEN_OFF;
    end else begin
      gen_ff <= nxt_gen;
    end
  end

  // ----------------------------------------------------------------
  // Hundred-meg one-then-zeros generator
  // ----------------------------------------------------------------
  logic [SEL_W:0] zcnt_ff;
  logic hund_bit;

  always_ff @(posedge ref_clk) begin
    if (reset || gen_ff != PTP_GEN_HUNDRED || zeros_ff == '0) begin
      zcnt_ff <= '0; // [R5]
    end else if (zcnt_ff == zeros_ff) begin
      zcnt_ff <= '0;
    end else begin
      zcnt_ff <= zcnt_ff + 1'b1;
    end
  end

  assign hund_bit = (zeros_ff != '0) && (zcnt_ff == '0); // [R4] [R5]

  // ----------------------------------------------------------------
  // Ten-meg pattern generator
  // ----------------------------------------------------------------
  logic [15:0] lfsr_ff;
  logic [1:0] phase_ff;
  logic first_ff;
  logic ten_bit;
  logic ten_idle;
  logic [1:0] ten_code;

  always_ff @(posedge ref_clk) begin
    if (reset || gen_ff != PTP_GEN_TEN) begin
      lfsr_ff <= LFSR_SEED;
      phase_ff <= '0;
      first_ff <= 1'b1;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      phase_ff <= phase_ff + 1'b1;
      first_ff <= 1'b0;
    end
  end

  // One-shot patterns send their bit in the first cycle and then idle.
  always_comb begin
    ten_bit = 1'b0;
    ten_idle = 1'b0;
    ten_code = IDLE_CODE_00;
    unique case (ten_sel_ff)
      PAT_LINK_PULSE, PAT_PULSE_ONE, PAT_ONE_IDLE: begin
        ten_bit = first_ff;
        ten_idle = !first_ff;
      end
      PAT_PULSE_ZERO, PAT_ZERO_IDLE: begin
        ten_bit = 1'b0;
        ten_idle = !first_ff;
      end
      PAT_REP_ONE: ten_bit = 1'b1;
      PAT_REP_ZERO: ten_bit = 1'b0;
      PAT_PREAMBLE: ten_bit = !phase_ff[0];
      PAT_SEQ_1001: ten_bit = phase_ff[0] ~^ phase_ff[1];
      PAT_RANDOM: ten_bit = lfsr_ff[0];
      PAT_IDLE_00: begin
        ten_idle = 1'b1;
        ten_code = IDLE_CODE_00;
      end
      PAT_IDLE_01: begin
        ten_idle = 1'b1;
        ten_code = IDLE_CODE_01;
      end
      PAT_IDLE_11: begin
        ten_idle = 1'b1;
        ten_code = IDLE_CODE_11;
      end
      default: ten_idle = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Transmit test outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      test_active_ff <= 1'b0;
      test_hundred_ff <= 1'b0;
      test_bit_ff <= 1'b0;
      test_idle_ff <= 1'b0;
      test_idle_code_ff <= IDLE_CODE_00;
    end else begin
      test_active_ff <= gen_ff != PTP_GEN_OFF; // [R1] [R2]
      test_hundred_ff <= gen_ff == PTP_GEN_HUNDRED;
      unique case (gen_ff)
        PTP_GEN_HUNDRED: begin
          test_bit_ff <= hund_bit;
          test_idle_ff <= 1'b0;
          test_idle_code_ff <= IDLE_CODE_00;
        end
        PTP_GEN_TEN: begin
          test_bit_ff <= ten_bit; // [R3]
          test_idle_ff <= ten_idle;
          test_idle_code_ff <= ten_code;
        end
        PTP_GEN_OFF: begin
          test_bit_ff <= 1'b0;
          test_idle_ff <= 1'b0;
          test_idle_code_ff <= IDLE_CODE_00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ten-meg receive preamble check
  // ----------------------------------------------------------------
  ptp_preamble_check u_pre (
    .ref_clk(ref_clk),
    .reset(reset),
    .short_mode(ten_meg_preamble_config_ff[BIT_PREAMBLE_MODE]), // [R8] [R13]
    .speed_100(speed_100),
    .rx_crs(rx_crs),
    .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte),
    .mac_valid_ff(mac_valid_ff),
    .mac_byte_ff(mac_byte_ff),
    .frame_ok_ff(frame_ok_ff),
    .frame_drop_ff(frame_drop_ff)
  );

endmodule // ptp_cfg

// >>> core/ptp_pkg.sv
package ptp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] OFF_COMPLIANCE_TEST_SELECT = 16'h0027;
  localparam logic [15:0] OFF_TEN_MEG_PREAMBLE_CONFIG = 16'h002A;
  localparam logic [15:0] OFF_HUNDRED_TEST_EXT = 16'h0428;

  localparam logic [15:0] RST_COMPLIANCE_TEST_SELECT = 16'h0000;
  localparam logic [15:0] RST_TEN_MEG_PREAMBLE_CONFIG = 16'h4000;
  localparam logic [15:0] RST_HUNDRED_TEST_EXT = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_TEST_ENABLE = 4;
  localparam int BIT_HUNDRED_SEL_HI = 5;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam int BIT_PREAMBLE_MODE = 14;
  localparam int BIT_PREAMBLE_RSVD_RO = 15;

  // ----------------------------------------------------------------
  // Ten-meg test pattern codes
  // ----------------------------------------------------------------
  localparam logic [3:0] PAT_LINK_PULSE = 4'h0;
  localparam logic [3:0] PAT_PULSE_ONE = 4'h1;
  localparam logic [3:0] PAT_PULSE_ZERO = 4'h2;
  localparam logic [3:0] PAT_REP_ONE = 4'h3;
  localparam logic [3:0] PAT_REP_ZERO = 4'h4;
  localparam logic [3:0] PAT_PREAMBLE = 4'h5;
  localparam logic [3:0] PAT_ONE_IDLE = 4'h6;
  localparam logic [3:0] PAT_ZERO_IDLE = 4'h7;
  localparam logic [3:0] PAT_SEQ_1001 = 4'h8;
  localparam logic [3:0] PAT_RANDOM = 4'h9;
  localparam logic [3:0] PAT_IDLE_00 = 4'hA;
  localparam logic [3:0] PAT_IDLE_01 = 4'hB;
  localparam logic [3:0] PAT_IDLE_11 = 4'hC;
  localparam logic [1:0] IDLE_CODE_00 = 2'h0;
  localparam logic [1:0] IDLE_CODE_01 = 2'h1;
  localparam logic [1:0] IDLE_CODE_11 = 2'h3;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // ----------------------------------------------------------------
  // Ten-meg receive preamble
  // ----------------------------------------------------------------
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam int LONG_PREAMBLE_BYTES = 7;
  localparam int SHORT_PREAMBLE_MIN_BYTES = 3;
  localparam int PRE_CNT_W = 4;

  typedef enum logic [1:0] {
    PTP_GEN_OFF,
    PTP_GEN_TEN,
    PTP_GEN_HUNDRED
  } ptp_gen_t;

  typedef enum logic [1:0] {
    PTP_RX_IDLE,
    PTP_RX_PRE,
    PTP_RX_DATA,
    PTP_RX_DROP
  } ptp_rx_t;

endpackage

// >>> core/ptp_preamble_check.sv
`timescale 1ns/1ps
module ptp_preamble_check (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic short_mode,
  input wire logic speed_100,
  input wire logic rx_crs,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  output logic mac_valid_ff,
  output logic [7:0] mac_byte_ff,
  output logic frame_ok_ff,
  output logic frame_drop_ff
);
  import ptp_pkg::*;

  ptp_rx_t state_ff;
  ptp_rx_t nxt_state;
  logic [PRE_CNT_W-1:0] pre_cnt_ff;
  logic enough;

  // ----------------------------------------------------------------
  // Preamble threshold
  // ----------------------------------------------------------------
  // In 100 Mbps the preamble mode has no say and an SFD after any number of preamble bytes is taken.
  always_comb begin
    if (speed_100) begin
      enough = 1'b1; // [R9]
    end else if (short_mode) begin
      enough = (pre_cnt_ff > PRE_CNT_W'(SHORT_PREAMBLE_MIN_BYTES)); // [R11]
    end else begin
      enough = (pre_cnt_ff >= PRE_CNT_W'(LONG_PREAMBLE_BYTES)); // [R10]
    end
  end

  always_comb begin
    nxt_state = state_ff;
    if (!rx_crs) begin
      nxt_state = PTP_RX_IDLE;
    end else if (rx_byte_valid) begin
      unique case (state_ff)
        PTP_RX_IDLE, PTP_RX_PRE: begin
          if (rx_byte == PREAMBLE_BYTE) begin
            nxt_state = PTP_RX_PRE;
          end else if (rx_byte == SFD_BYTE && enough) begin
            nxt_state = PTP_RX_DATA;
          end else begin
            nxt_state = PTP_RX_DROP;
          end
        end
        PTP_RX_DATA: nxt_state = PTP_RX_DATA;
        PTP_RX_DROP: nxt_state = PTP_RX_DROP;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= PTP_RX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !rx_crs) begin
      pre_cnt_ff <= '0;
    end else if (rx_byte_valid && rx_byte == PREAMBLE_BYTE && pre_cnt_ff != '1) begin
      pre_cnt_ff <= pre_cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // MAC side
  // ----------------------------------------------------------------
  // Line preamble bytes are consumed here; the MAC sees the SFD and data only.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mac_valid_ff <= 1'b0;
      mac_byte_ff <= 8'h00;
    end else begin
      mac_valid_ff <= rx_crs && rx_byte_valid && nxt_state == PTP_RX_DATA; // [R12]
      mac_byte_ff <= rx_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_ok_ff <= 1'b0;
      frame_drop_ff <= 1'b0;
    end else begin
      frame_ok_ff <= state_ff != PTP_RX_DATA && nxt_state == PTP_RX_DATA;
      frame_drop_ff <= state_ff != PTP_RX_DROP && nxt_state == PTP_RX_DROP;
    end
  end

endmodule // ptp_preamble_check

// >>> sim/ptp_cfg_asserts.sv
`timescale 1ns/1ps
module ptp_cfg_asserts
  import ptp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_ff,
  input wire logic rx_crs,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic test_active_ff,
  input wire logic test_hundred_ff,
  input wire logic test_bit_ff,
  input wire logic mac_valid_ff,
  input wire logic [7:0] mac_byte_ff,
  input wire logic frame_ok_ff,
  input wire logic frame_drop_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence wr_then_rd_s;
    (reg_wr && reg_addr == OFF_COMPLIANCE_TEST_SELECT) ##1
      (reg_rd && reg_addr == OFF_COMPLIANCE_TEST_SELECT);
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr != OFF_COMPLIANCE_TEST_SELECT
    && reg_addr != OFF_TEN_MEG_PREAMBLE_CONFIG && reg_addr != OFF_HUNDRED_TEST_EXT
    |=> reg_rdata_ff == 16'h0000) else $error("unmapped read not zero");
  cfg_rsvd_a: assert property (reg_rd && reg_addr == OFF_TEN_MEG_PREAMBLE_CONFIG
    |=> !reg_rdata_ff[15]) else $error("reserved preamble bit reads one");
  ext_bits_a: assert property (reg_rd && reg_addr == OFF_HUNDRED_TEST_EXT
    |=> (reg_rdata_ff & 16'hFFCF) == 16'h0000) else $error("extended register extra bits");
  wr_readback_a: assert property (wr_then_rd_s |=> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("test select readback wrong");
  hundred_stop_a: assert property (reg_wr && reg_addr == OFF_HUNDRED_TEST_EXT
    && !reg_wdata[4] |-> ##[1:4] !test_hundred_ff) else $error("hundred test kept running");
  sfd_cause_a: assert property (frame_ok_ff |->
    $past(rx_crs && rx_byte_valid && rx_byte == SFD_BYTE)) else $error("frame ok without SFD");
  mac_byte_a: assert property (mac_valid_ff |->
    $past(rx_byte_valid) && mac_byte_ff == $past(rx_byte)) else $error("forwarded byte wrong");
  no_carrier_a: assert property (!rx_crs |=> !mac_valid_ff && !frame_ok_ff)
    else $error("output without carrier");
  bit_needs_test_a: assert property (test_bit_ff |-> test_active_ff)
    else $error("test bit outside test");
  cover property (frame_ok_ff);
  cover property (frame_drop_ff);
  cover property ($rose(test_hundred_ff));
endmodule // ptp_cfg_asserts
bind ptp_cfg ptp_cfg_asserts u_chk (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .rx_crs(rx_crs), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
  .test_active_ff(test_active_ff), .test_hundred_ff(test_hundred_ff),
  .test_bit_ff(test_bit_ff), .mac_valid_ff(mac_valid_ff), .mac_byte_ff(mac_byte_ff),
  .frame_ok_ff(frame_ok_ff), .frame_drop_ff(frame_drop_ff));

// >>> sim/ptp_link_partner.sv
`timescale 1ns/1ps
module ptp_link_partner
  import ptp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [3:0] pre_len,
  input wire logic [3:0] data_len,
  input wire logic slow,
  input wire logic bad,
  output logic busy,
  output logic rx_crs,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte
);
  logic [7:0] b;
  initial begin
    busy = 1'b0;
    rx_crs = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'hAA;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        rx_crs <= 1'b1;
        for (int i = 0; i <= pre_len + data_len; i++) begin
          if (i < pre_len) b = (bad && i == 1) ? 8'h12 : PREAMBLE_BYTE;
          else if (i == pre_len) b = SFD_BYTE;
          else b = 8'h3C ^ 8'(i);
          rx_byte_valid <= 1'b1;
          rx_byte <= b;
          @(posedge ref_clk);
          if (slow) begin
            rx_byte_valid <= 1'b0;
            rx_byte <= ~b;
            @(posedge ref_clk);
          end
        end
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
        rx_crs <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule // ptp_link_partner

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ptp_pkg::*;
  logic ref_clk, reset, reg_wr, reg_rd, speed_100, go, slow, bad, busy;
  logic rx_crs, rx_byte_valid, test_active_ff, test_hundred_ff, test_bit_ff, test_idle_ff;
  logic mac_valid_ff, frame_ok_ff, frame_drop_ff;
  logic [15:0] reg_addr, reg_wdata, reg_rdata_ff, rv;
  logic [7:0] rx_byte, mac_byte_ff, first_byte;
  logic [3:0] pre_len, data_len;
  logic [1:0] test_idle_code_ff;
  logic [63:0] bits;
  int failures, cmp_count, n_ok, n_drop, n_mac;
  integer seed;
  logic [4:0] hun_n[6] = '{5'd1, 5'd3, 5'd15, 5'd16, 5'd31, 5'd0};
  int pre_n[6] = '{2, 3, 4, 6, 7, 8};
  ptp_cfg dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .speed_100(speed_100),
    .rx_crs(rx_crs), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .test_active_ff(test_active_ff), .test_hundred_ff(test_hundred_ff),
    .test_bit_ff(test_bit_ff), .test_idle_ff(test_idle_ff),
    .test_idle_code_ff(test_idle_code_ff), .mac_valid_ff(mac_valid_ff),
    .mac_byte_ff(mac_byte_ff), .frame_ok_ff(frame_ok_ff), .frame_drop_ff(frame_drop_ff));
  ptp_link_partner u_lp (.ref_clk(ref_clk), .go(go), .pre_len(pre_len), .data_len(data_len),
    .slow(slow), .bad(bad), .busy(busy), .rx_crs(rx_crs), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Frame outcome is tallied on the falling edge, clear of the launch edge.
  always @(negedge ref_clk) begin
    if (frame_ok_ff === 1'b1) n_ok++;
    if (frame_drop_ff === 1'b1) n_drop++;
    if (mac_valid_ff === 1'b1) begin
      if (n_mac == 0) first_byte = mac_byte_ff;
      n_mac++;
    end
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
  task automatic grab(input int n);
    repeat (8) @(posedge ref_clk);
    bits = '0;
    for (int t = 0; t < n; t++) begin
      @(posedge ref_clk);
      #1 bits[t] = test_bit_ff;
    end
  endtask
  function automatic logic pat_ok(input logic [3:0] s, input logic [15:0] v);
    case (s)
      PAT_REP_ONE: return v === 16'hFFFF;
      PAT_REP_ZERO: return v === 16'h0000;
      PAT_PREAMBLE: return v === 16'h5555 || v === 16'hAAAA;
      PAT_SEQ_1001: return v === 16'h9999 || v === 16'h3333 || v === 16'h6666 || v === 16'hCCCC;
      PAT_RANDOM: return v !== 16'h0000 && v !== 16'hFFFF;
      PAT_IDLE_00: return test_idle_ff === 1'b1 && test_idle_code_ff === IDLE_CODE_00;
      PAT_IDLE_01: return test_idle_ff === 1'b1 && test_idle_code_ff === IDLE_CODE_01;
      PAT_IDLE_11: return test_idle_ff === 1'b1 && test_idle_code_ff === IDLE_CODE_11;
      default: return test_idle_ff === 1'b1 && v === 16'h0000;
    endcase
  endfunction
  function automatic logic hun_ok(input int n, input logic [63:0] b);
    int p;
    p = -1;
    for (int t = 0; t < 64; t++) if (b[t] === 1'b1 && p < 0) p = t;
    if (n == 0) return b === 64'h0;
    if (p < 0 || p > n) return 1'b0;
    for (int t = 0; t < 64; t++) if (b[t] !== (t >= p && (t - p) % (n + 1) == 0)) return 1'b0;
    return 1'b1;
  endfunction
  function automatic logic acc(input logic sh, input logic sp, input int np, input logic bd);
    if (bd) return 1'b0;
    if (sp) return 1'b1;
    return np >= (sh ? 4 : LONG_PREAMBLE_BYTES);
  endfunction
  task automatic hun(input logic [4:0] n);
    speed_100 <= 1'b1;
    wr(OFF_HUNDRED_TEST_EXT, 16'h0000);
    wr(OFF_COMPLIANCE_TEST_SELECT, {12'h000, n[3:0]});
    wr(OFF_HUNDRED_TEST_EXT, {10'h000, n[4], 5'h10});
    for (int k = 0; k < 2; k++) begin
      grab(64);
      chk("hundred pattern", hun_ok(n, bits), 1);
      if (n != 0) chk("hundred active", test_hundred_ff, 1);
      wr(OFF_COMPLIANCE_TEST_SELECT, {12'h000, n[3:0] ^ 4'h5});
    end
    wr(OFF_HUNDRED_TEST_EXT, 16'h0000);
    $display("hundred test n=%0d done", n);
  endtask
  task automatic frame(input logic sh, input logic sp, input int np, input int dl, input logic bd);
    logic e;
    e = acc(sh, sp, np, bd);
    wr(OFF_TEN_MEG_PREAMBLE_CONFIG, sh ? 16'h4000 : 16'h0000);
    n_ok = 0;
    n_drop = 0;
    n_mac = 0;
    @(posedge ref_clk);
    speed_100 <= sp;
    go <= 1'b1;
    pre_len <= 4'(np);
    data_len <= 4'(dl);
    bad <= bd;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    for (int w = 0; w < 100 && busy !== 1'b0; w++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk("frame ok", n_ok, e);
    chk("frame drop", n_drop != 0, !e);
    chk("mac bytes", n_mac, e ? dl + 1 : 0);
    if (e) chk("first mac byte", first_byte, SFD_BYTE);
    $display("frame pre=%0d short=%0d fast=%0d done", np, sh, sp);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    final_report();
  end
  initial begin
    seed = 32'h0c8e;
    {reset, reg_wr, reg_rd, speed_100, go, slow, bad} = 7'h40;
    reg_addr = '0;
    reg_wdata = '0;
    pre_len = '0;
    data_len = '0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(OFF_COMPLIANCE_TEST_SELECT, rv);
    chk("test select reset", rv, RST_COMPLIANCE_TEST_SELECT);
    rd(OFF_TEN_MEG_PREAMBLE_CONFIG, rv);
    chk("preamble cfg reset", rv, 16'h4000);
    rd(OFF_HUNDRED_TEST_EXT, rv);
    chk("extended reset", rv, 16'h0000);
    wr(OFF_TEN_MEG_PREAMBLE_CONFIG, 16'hFFFF);
    rd(OFF_TEN_MEG_PREAMBLE_CONFIG, rv);
    chk("preamble cfg rw", rv, 16'h7FFF);
    wr(16'h0100, 16'hFFFF);
    rd(16'h0100, rv);
    chk("unmapped", rv, 16'h0000);
    wr(OFF_HUNDRED_TEST_EXT, 16'hFFEF);
    rd(OFF_HUNDRED_TEST_EXT, rv);
    chk("extended rw", rv, 16'h0020);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= OFF_COMPLIANCE_TEST_SELECT;
    reg_wdata <= 16'h0003;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata_ff;
    chk("write then read", rv, 16'h0003);
    wr(OFF_HUNDRED_TEST_EXT, 16'h0000);
    $display("register test done");
    for (int s = 0; s < 16; s++) begin
      wr(OFF_COMPLIANCE_TEST_SELECT, 16'h0000);
      wr(OFF_COMPLIANCE_TEST_SELECT, 16'(s) | 16'h0010);
      grab(16);
      chk("ten pattern", pat_ok(4'(s), bits[15:0]), 1);
      chk("ten active", {test_active_ff, test_hundred_ff}, 2'b10);
    end
    wr(OFF_COMPLIANCE_TEST_SELECT, 16'h0000);
    $display("ten-meg pattern test done");
    foreach (hun_n[i]) hun(hun_n[i]);
    hun(5'($random(seed)));
    for (int m = 0; m < 4; m++) begin
      foreach (pre_n[i]) frame(m[0], m[1], pre_n[i], 2, 1'b0);
    end
    frame(1'b1, 1'b0, 8, 2, 1'b1);
    for (int r = 0; r < 10; r++) begin
      slow <= 1'($random(seed));
      frame(1'($random(seed)), 1'($random(seed)), 1 + {$random(seed)} % 12, 1 + {$random(seed)} % 4, 1'b0);
    end
    final_report();
  end
endmodule // tb_top
